// [design/gq_pkg.sv]
package gq_pkg;

    // ============================================================
    // geometry
    localparam int unsigned PINS_PER_PORT = 32;
    localparam int unsigned PINS_PER_MUX  = 16;
    localparam int unsigned NUM_MUX_REGS  = 3;
    localparam int unsigned NUM_PINS      = 48;
    localparam int unsigned GROUP_SIZE    = 8;
    localparam int unsigned NUM_GROUPS    = NUM_PINS / GROUP_SIZE;
    localparam int unsigned NUM_PERIPH    = 8;
    localparam int unsigned PRD_W         = 8;

    // ============================================================
    // register byte offsets
    localparam logic [7:0] OFS_PORT_A_LOW_FUNC  = 8'h00;
    localparam logic [7:0] OFS_PORT_A_HIGH_FUNC = 8'h04;
    localparam logic [7:0] OFS_PORT_B_LOW_FUNC  = 8'h08;
    localparam logic [7:0] OFS_QUAL_SEL_A_LOW   = 8'h0c;
    localparam logic [7:0] OFS_QUAL_SEL_A_HIGH  = 8'h10;
    localparam logic [7:0] OFS_QUAL_SEL_B_LOW   = 8'h14;
    localparam logic [7:0] OFS_PORT_CTRL_A      = 8'h18;
    localparam logic [7:0] OFS_PORT_CTRL_B      = 8'h1c;
    localparam logic [7:0] OFS_PIN_STATE_A      = 8'h20;
    localparam logic [7:0] OFS_PIN_STATE_B      = 8'h24;

    // ============================================================
    // reset values
    localparam logic [31:0] RST_FUNC_SEL  = 32'h0000_0000;
    localparam logic [31:0] RST_QUAL_SEL  = 32'h0000_0000;
    localparam logic [31:0] RST_PORT_CTRL = 32'h0000_0000;

    // ============================================================
    // qualification modes
    typedef enum logic [1:0] {
        GQ_SYNC_ONLY = 2'b00,
        GQ_WIN3      = 2'b01,
        GQ_WIN6      = 2'b10,
        GQ_ASYNC     = 2'b11
    } gq_qual_t;

    localparam int unsigned WIN3_LEN = 3;
    localparam int unsigned WIN6_LEN = 6;

    // ============================================================
    // ahb-lite
    localparam logic [1:0] HTRANS_IDLE   = 2'b00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

endpackage : gq_pkg

// [design/gq_pin_qual.sv]
`timescale 1ns/100ps
module gq_pin_qual
    import gq_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             pin_in,
    input  wire logic [1:0]       qual_mode,
    input  wire logic             sample_tick,
    output logic                  qual_out
);
    import gq_pkg::*;

    logic [2:0] sync_q;
    logic [5:0] win;
    logic       filt;
    logic [5:0] next_win;
    logic       next_filt;
    logic       synced;
    logic       all1;
    logic       all0;
    logic       filt_hold;
    logic       next_filt_hold;

    // ============================================================
    // synchroniser: stage 0 read only by stage 1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], pin_in};
        end
    end

    // settled level once stages 1 and 2 agree
    always_comb begin
        synced = (sync_q[1] == sync_q[2]) ? sync_q[2] : filt_hold;
    end

    // ============================================================
    // sampling window
    always_comb begin
        next_win       = win;
        next_filt      = filt;
        next_filt_hold = synced;
        all1           = 1'b0;
        all0           = 1'b0;
        if (sample_tick) begin
            next_win = {win[4:0], synced}; // [RULE6]
        end
        if (qual_mode == GQ_WIN3) begin // [RULE11]
            all1 = &next_win[WIN3_LEN-1:0];
            all0 = ~|next_win[WIN3_LEN-1:0];
        end else begin
            all1 = &next_win;
            all0 = ~|next_win;
        end
        if (all1) begin // [RULE7]
            next_filt = 1'b1;
        end else if (all0) begin
            next_filt = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win       <= 6'h00;
            filt      <= 1'b0;
            filt_hold <= 1'b0;
        end else begin
            win       <= next_win;
            filt      <= next_filt;
            filt_hold <= next_filt_hold;
        end
    end

    // ============================================================
    // output select
    always_comb begin
        unique case (qual_mode)
            GQ_SYNC_ONLY: qual_out = synced; // [RULE3]
            GQ_WIN3:      qual_out = filt;   // [RULE4]
            GQ_WIN6:      qual_out = filt;   // [RULE4]
            GQ_ASYNC:     qual_out = pin_in; // [RULE8]
        endcase
    end

endmodule : gq_pin_qual

// [design/gq_top.sv]
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
// Behaviour
// [RULE1] each pin has own two-bit function field
// [RULE2] reserved function code connects no peripheral
// [RULE3] mode 00 synchronises only, reset default; the code in mode 00 also drops pulses one clock cycle long
// [RULE4] modes 01/10 synchronise then filter changes
// [RULE5] sample period shared per eight pins
// [RULE6] sample interval is twice the period in clock cycles
// [RULE7] output changes only on unanimous window
// [RULE8] mode 11 passes input unsynchronised
// [RULE9] one peripheral input fed by several pins
// [RULE10] unselected peripheral input sits at default
// [RULE11] 01 is three samples, 10 six
// [RULE12] period zero every cycle, else twice
module gq_top #(
    parameter logic [gq_pkg::NUM_PERIPH-1:0] PERIPH_DEFAULT = '0
) (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic [31:0]                        hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic [gq_pkg::NUM_PINS-1:0]   pin_in,
    output logic [gq_pkg::NUM_PINS-1:0]        pin_qual,
    output logic [gq_pkg::NUM_PERIPH-1:0]      periph_in,
    output logic [gq_pkg::NUM_PERIPH-1:0]      periph_connected
);
    import gq_pkg::*;

    // ============================================================
    // registers
    logic [31:0] func_sel [NUM_MUX_REGS];
    logic [31:0] qual_sel [NUM_MUX_REGS];
    logic [31:0] port_ctrl [2];
    logic [31:0] next_func_sel [NUM_MUX_REGS];
    logic [31:0] next_qual_sel [NUM_MUX_REGS];
    logic [31:0] next_port_ctrl [2];

    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        next_wr_pend;
    logic [7:0]  next_wr_addr;
    logic [31:0] next_hrdata;
    logic        take;

    // ============================================================
    // per-pin fields
    logic [1:0] func_of [NUM_PINS];
    logic [1:0] mode_of [NUM_PINS];
    logic [NUM_PINS-1:0] qual_w;
    logic [NUM_GROUPS-1:0] tick;

    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : g_pin
            localparam int unsigned R = p / PINS_PER_MUX;
            localparam int unsigned F = (p % PINS_PER_MUX) * 2;
            assign func_of[p] = func_sel[R][F+1:F]; // [RULE1]
            assign mode_of[p] = qual_sel[R][F+1:F];
            gq_pin_qual u_qual (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .pin_in      (pin_in[p]),
                .qual_mode   (mode_of[p]),
                .sample_tick (tick[p / GROUP_SIZE]),
                .qual_out    (qual_w[p])
            );
        end
    endgenerate

    // ============================================================
    // sample period counters, one per group of eight
    logic [PRD_W:0] cnt [NUM_GROUPS];
    logic [PRD_W:0] next_cnt [NUM_GROUPS];
    logic [PRD_W-1:0] prd_of [NUM_GROUPS];

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
            localparam int unsigned PR = (g * GROUP_SIZE) / PINS_PER_PORT;
            localparam int unsigned PB = (((g * GROUP_SIZE) % PINS_PER_PORT) / GROUP_SIZE)
                                         * PRD_W;
            assign prd_of[g] = port_ctrl[PR][PB+PRD_W-1:PB]; // [RULE5]
            always_comb begin
                next_cnt[g] = cnt[g] + 1'b1;
                tick[g]     = 1'b0;
                // twice the setting, zero ticks every cycle
                if (cnt[g] >= {prd_of[g], 1'b0} - 1'b1 || prd_of[g] == '0) begin // [RULE12]
                    next_cnt[g] = '0;
                    tick[g]     = 1'b1; // [RULE6]
                end
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt[g] <= '0;
                end else begin
                    cnt[g] <= next_cnt[g];
                end
            end
        end
    endgenerate

    // ============================================================
    // peripheral routing: pin candidates per peripheral input
    // each entry: pin index and function code; a peripheral may list two pins
    localparam int unsigned ROUTES = 2;
    localparam logic [5:0] ROUTE_PIN  [NUM_PERIPH][ROUTES] = '{
        '{6'd10, 6'd13}, '{6'd11, 6'd15}, '{6'd12, 6'd16}, '{6'd13, 6'd17},
        '{6'd20, 6'd20}, '{6'd21, 6'd21}, '{6'd28, 6'd28}, '{6'd30, 6'd30}
    };
    localparam logic [1:0] ROUTE_FUNC [NUM_PERIPH][ROUTES] = '{
        '{2'd2, 2'd2}, '{2'd2, 2'd2}, '{2'd1, 2'd3}, '{2'd1, 2'd3},
        '{2'd1, 2'd1}, '{2'd1, 2'd1}, '{2'd1, 2'd1}, '{2'd1, 2'd1}
    };

    logic [NUM_PERIPH-1:0] next_periph_in;
    logic [NUM_PERIPH-1:0] next_periph_conn;

    // lowest route wins if software selects both; reserved codes never match
    always_comb begin
        for (int i = 0; i < NUM_PERIPH; i++) begin
            next_periph_in[i]   = PERIPH_DEFAULT[i]; // [RULE10]
            next_periph_conn[i] = 1'b0;
            for (int k = ROUTES - 1; k >= 0; k--) begin
                if (func_of[ROUTE_PIN[i][k]] == ROUTE_FUNC[i][k]) begin // [RULE9] [RULE2]
                    next_periph_in[i]   = qual_w[ROUTE_PIN[i][k]];
                    next_periph_conn[i] = 1'b1;
                end
            end
        end
    end

    // async mode bypass still lands in a flop here; peripheral resyncs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // unrouted inputs sit at their default even while in reset
            pin_qual         <= '0;
            periph_in        <= PERIPH_DEFAULT; // [RULE10]
            periph_connected <= '0;
        end else begin
            pin_qual         <= qual_w;
            periph_in        <= next_periph_in;
            periph_connected <= next_periph_conn;
        end
    end

    // ============================================================
    // ahb-lite slave, zero wait states
    always_comb begin
        take         = hsel && hready && (htrans == HTRANS_NONSEQ);
        next_wr_pend = take && hwrite;
        next_wr_addr = haddr[7:0];
        next_hrdata  = 32'h0000_0000;
        for (int r = 0; r < NUM_MUX_REGS; r++) begin
            next_func_sel[r] = func_sel[r];
            next_qual_sel[r] = qual_sel[r];
        end
        next_port_ctrl[0] = port_ctrl[0];
        next_port_ctrl[1] = port_ctrl[1];
        if (wr_pend) begin
            unique case (wr_addr)
                OFS_PORT_A_LOW_FUNC:  next_func_sel[0]  = hwdata;
                OFS_PORT_A_HIGH_FUNC: next_func_sel[1]  = hwdata;
                OFS_PORT_B_LOW_FUNC:  next_func_sel[2]  = hwdata;
                OFS_QUAL_SEL_A_LOW:   next_qual_sel[0]  = hwdata;
                OFS_QUAL_SEL_A_HIGH:  next_qual_sel[1]  = hwdata;
                OFS_QUAL_SEL_B_LOW:   next_qual_sel[2]  = hwdata;
                OFS_PORT_CTRL_A:      next_port_ctrl[0] = hwdata;
                OFS_PORT_CTRL_B:      next_port_ctrl[1] = {16'h0000, hwdata[15:0]};
                default:              ;
            endcase
        end
        if (take && !hwrite) begin
            unique case (haddr[7:0])
                OFS_PORT_A_LOW_FUNC:  next_hrdata = func_sel[0];
                OFS_PORT_A_HIGH_FUNC: next_hrdata = func_sel[1];
                OFS_PORT_B_LOW_FUNC:  next_hrdata = func_sel[2];
                OFS_QUAL_SEL_A_LOW:   next_hrdata = qual_sel[0];
                OFS_QUAL_SEL_A_HIGH:  next_hrdata = qual_sel[1];
                OFS_QUAL_SEL_B_LOW:   next_hrdata = qual_sel[2];
                OFS_PORT_CTRL_A:      next_hrdata = port_ctrl[0];
                OFS_PORT_CTRL_B:      next_hrdata = port_ctrl[1];
                OFS_PIN_STATE_A:      next_hrdata = qual_w[31:0];
                OFS_PIN_STATE_B:      next_hrdata = {16'h0000, qual_w[47:32]};
                default:              next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int r = 0; r < NUM_MUX_REGS; r++) begin
                func_sel[r] <= RST_FUNC_SEL;
                qual_sel[r] <= RST_QUAL_SEL; // [RULE3]
            end
            port_ctrl[0] <= RST_PORT_CTRL;
            port_ctrl[1] <= RST_PORT_CTRL;
            wr_pend      <= 1'b0;
            wr_addr      <= 8'h00;
            hrdata       <= 32'h0000_0000;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
        end else begin
            for (int r = 0; r < NUM_MUX_REGS; r++) begin
                func_sel[r] <= next_func_sel[r];
                qual_sel[r] <= next_qual_sel[r];
            end
            port_ctrl[0] <= next_port_ctrl[0];
            port_ctrl[1] <= next_port_ctrl[1];
            wr_pend      <= next_wr_pend;
            wr_addr      <= next_wr_addr;
            hrdata       <= next_hrdata;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
        end
    end

endmodule : gq_top

// [verification/gq_pin_src.sv]
`timescale 1ns/100ps
module gq_pin_src
    import gq_pkg::*;
(
    input  wire logic [gq_pkg::NUM_PINS-1:0] level,
    output wire logic [gq_pkg::NUM_PINS-1:0] pin_in
);
    // ============================================================
    // pins move 7 ns after level changes, never in step with the clock
    assign #7 pin_in = level;
endmodule : gq_pin_src

// [verification/gq_top_chk.sv]
`timescale 1ns/100ps
module gq_top_chk
    import gq_pkg::*;
#(
    parameter logic [gq_pkg::NUM_PERIPH-1:0] PERIPH_DEFAULT = '0
) (
    input wire logic                          hclk,
    input wire logic                          hresetn,
    input wire logic                          hsel,
    input wire logic [31:0]                   haddr,
    input wire logic [1:0]                    htrans,
    input wire logic                          hwrite,
    input wire logic [2:0]                    hsize,
    input wire logic [31:0]                   hwdata,
    input wire logic                          hready,
    input wire logic [31:0]                   hrdata,
    input wire logic                          hreadyout,
    input wire logic                          hresp,
    input wire logic [gq_pkg::NUM_PINS-1:0]   pin_in,
    input wire logic [gq_pkg::NUM_PINS-1:0]   pin_qual,
    input wire logic [gq_pkg::NUM_PERIPH-1:0] periph_in,
    input wire logic [gq_pkg::NUM_PERIPH-1:0] periph_connected
);
    logic rd_take;
    logic wr_take;
    logic wrote;
    logic next_wrote;
    assign rd_take = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    assign wr_take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
    // ============================================================
    // remembers whether software wrote anything since reset
    always_comb next_wrote = wrote || wr_take;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wrote <= 1'b0;
        else wrote <= next_wrote;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ============================================================
    // bus
    resp_okay_a: assert property (!hresp && hreadyout) else $error("bus answer not okay");
    rdata_idle_a: assert property (!rd_take |=> hrdata == '0) else $error("stale read data");
    unmapped_zero_a: assert property (rd_take && haddr[7:0] >= 8'h28 |=> hrdata == '0)
        else $error("unmapped read not zero");
    ctrl_b_upper_a: assert property (
        rd_take && haddr[7:0] == OFS_PORT_CTRL_B |=> hrdata[31:16] == '0)
        else $error("missing groups not zero");
    state_b_upper_a: assert property (rd_take && haddr[7:0] == OFS_PIN_STATE_B
        |=> hrdata[31:16] == '0) else $error("absent pins not zero");
    // ============================================================
    // pins and routing
    sync_high_a: assert property ((!wrote && &pin_in)[*8] |-> &pin_qual)
        else $error("reset mode lost high level");
    sync_low_a: assert property ((!wrote && !(|pin_in))[*8] |-> !(|pin_qual))
        else $error("reset mode lost low level");
    none_routed_a: assert property (!wrote |-> periph_connected == '0)
        else $error("route without selection");
    default_level_a: assert property ($stable(periph_connected) && $past(hresetn)
        |-> ((periph_in ^ PERIPH_DEFAULT) & ~periph_connected) == '0)
        else $error("unrouted input off default");
endmodule : gq_top_chk

bind gq_top gq_top_chk #(.PERIPH_DEFAULT(PERIPH_DEFAULT)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_qual(pin_qual),
    .periph_in(periph_in), .periph_connected(periph_connected)
);

// [verification/gq_top_test.sv]
`timescale 1ns/100ps
module gq_top_test;
    import gq_pkg::*;
    localparam logic [7:0] DEF = 8'h5a;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [47:0] level, pin_in, pin_qual;
    logic [7:0]  periph_in, periph_connected, seen;
    int          n_fail, num_checks, n0, n1, n7, n8, n9;

    gq_top #(.PERIPH_DEFAULT(DEF)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
        .pin_qual(pin_qual), .periph_in(periph_in), .periph_connected(periph_connected)
    );
    gq_pin_src u_pins (.level(level), .pin_in(pin_in));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ============================================================
    // helpers
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= HTRANS_NONSEQ; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= HTRANS_IDLE; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    // ============================================================
    // scenarios
    task t_reset;
        repeat (10) @(posedge hclk);
        #1 chk("pins high", pin_qual, '1);
        chk("unrouted level", periph_in, DEF);
        chk("nothing routed", periph_connected, 8'h0);
        level <= '0;
        repeat (10) @(posedge hclk);
        $display("t_reset done");
    endtask : t_reset
    task t_regs;
        logic [7:0]  a [5];
        logic [31:0] e [5];
        a = '{OFS_PORT_A_LOW_FUNC, OFS_QUAL_SEL_A_HIGH, OFS_PORT_CTRL_A,
              OFS_PORT_CTRL_B, 8'h30};
        e = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
              32'h0000_ffff, 32'h0000_0000};
        for (int i = 0; i < 5; i++) ahb(1'b1, a[i], 32'hffff_ffff);
        chk("reserved code", periph_connected, 8'h0);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, a[i], 32'h0);
            chk("register", rd, e[i]);
            ahb(1'b1, a[i], 32'h0);
        end
        $display("t_regs done");
    endtask : t_regs
    task t_async;
        ahb(1'b1, OFS_QUAL_SEL_A_LOW, 32'hffff_ffff);
        @(posedge hclk);
        level[15:0] <= 16'ha5c3;
        @(negedge hclk);
        chk("async early", pin_qual[15:0], 16'h0);
        @(posedge hclk);
        #1 chk("async", pin_qual[15:0], 16'ha5c3);
        level <= '0;
        ahb(1'b1, OFS_QUAL_SEL_A_LOW, 32'h0);
        repeat (8) @(posedge hclk);
        $display("t_async done");
    endtask : t_async
    task t_sync;
        @(posedge hclk);
        level[47:32] <= 16'h3c96;
        repeat (2) @(posedge hclk);
        #1 chk("sync early", pin_qual[47:32], 16'h0);
        repeat (6) @(posedge hclk);
        #1 chk("sync", pin_qual[47:32], 16'h3c96);
        ahb(1'b0, OFS_PIN_STATE_B, 32'h0);
        chk("pin state", rd, 32'h0000_3c96);
        level <= '0;
        $display("t_sync done");
    endtask : t_sync
    task t_window;
        seen = '0;
        ahb(1'b1, OFS_QUAL_SEL_A_LOW, 32'h0009_8009);
        ahb(1'b1, OFS_PORT_CTRL_A, 32'h0000_0002);
        repeat (10) @(posedge hclk);
        level[7:0] <= 8'h83;
        repeat (8) @(posedge hclk);
        level[7:0] <= 8'h00;
        repeat (40) begin
            @(posedge hclk);
            #1 seen = seen | pin_qual[7:0];
        end
        chk("glitch held", seen & 8'h83, 8'h0);
        level[9:0] <= 10'h383;
        for (int c = 1; c < 100; c++) begin
            @(posedge hclk);
            #1 if (!pin_qual[0]) n0 = c;
            if (!pin_qual[1]) n1 = c;
            if (!pin_qual[7]) n7 = c;
            if (!pin_qual[8]) n8 = c;
            if (!pin_qual[9]) n9 = c;
        end
        // rise seen 3 sync edges plus 3 ticks later; slow group tick phase unknown
        chk("three of six", n1 - n0, 12);
        chk("shared period", n7, n1);
        chk("every cycle", n9 - n8, 3);
        chk("three sample", n0 >= 12 && n0 <= 15, 1);
        chk("sync then three", n8, 6);
        level <= '0;
        ahb(1'b1, OFS_QUAL_SEL_A_LOW, 32'h0);
        ahb(1'b1, OFS_PORT_CTRL_A, 32'h0);
        repeat (10) @(posedge hclk);
        $display("t_window done");
    endtask : t_window
    task t_periph;
        level[10] <= 1'b1;
        ahb(1'b1, OFS_PORT_A_LOW_FUNC, 32'h0020_0000);
        repeat (10) @(posedge hclk);
        chk("first route", {periph_connected[0], periph_in[0]}, 2'b11);
        ahb(1'b1, OFS_PORT_A_LOW_FUNC, 32'h0800_0000);
        repeat (10) @(posedge hclk);
        chk("second route", {periph_connected[0], periph_in[0]}, 2'b10);
        level[13] <= 1'b1;
        ahb(1'b1, OFS_PORT_A_LOW_FUNC, 32'h0030_0000);
        repeat (10) @(posedge hclk);
        chk("reserved", {periph_connected[0], periph_in[0]}, {1'b0, DEF[0]});
        $display("t_periph done");
    endtask : t_periph
    task t_rerun;
        ahb(1'b1, OFS_QUAL_SEL_A_LOW, 32'h5555_5555);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, OFS_QUAL_SEL_A_LOW, 32'h0);
        chk("qual after reset", rd, 32'h0);
        ahb(1'b0, OFS_PORT_A_LOW_FUNC, 32'h0);
        chk("func after reset", rd, 32'h0);
        $display("t_rerun done");
    endtask : t_rerun

    initial begin
        #200000;
        n_fail++;
        end_sim;
    end

    initial begin
        n_fail = 0;
        num_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hwdata = '0;
        level = '1;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_regs;
        t_async;
        t_sync;
        t_window;
        t_periph;
        t_rerun;
        end_sim;
    end
endmodule : gq_top_test
